// ---- logic/tfc_fault_context.sv ----
// Translation fault context registers: faulting address, page table pointer,
// pointer field select and capability word, reached over classic Wishbone.
// Assumes exception strobe, cause code and address come from core logic on clk_i.
//
// How it works
// - Faulting address is 32-bit, read only.
// - Load address only on address/translation faults.
// - Table base bits are plain software storage.
// - Legacy mode: VA 31..13 into page number.
// - Page number undefined after address error.
// - Extended mode: top VA bits fill selected field.
// - Bits above field: software RW, exception-proof.
// - Bits below field always read zero.
// - Select bits 22:4 equal legacy layout.
// - Pointer unpredictable after select change.
// - All-ones select mirrors whole faulting address.
// - All-zeros select: pointer fully software owned.
// - Select register present when either capability set.
// - Some select bits may be fixed.
// - Support single-level 4K 64-bit select value.
// - Accept recommended 32-bit entry select values.
`timescale 1ns/1ps

module tfc_fault_context
	import tfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire tfc_pkg::tfc_addr_t wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire tfc_pkg::tfc_word_t wb_dat_i,
	output tfc_pkg::tfc_word_t wb_dat_o,
	output logic wb_ack_o,
	// Core exception sequencing
	input wire logic exc_strobe_i,
	input wire tfc_pkg::tfc_code_t exception_cause_code_i,
	input wire tfc_pkg::tfc_word_t exc_vaddr_i,
	// Capability straps from core configuration
	input wire logic extended_pointer_present_i,
	input wire logic smartmips_pointer_select_i,
	// Views for the refill path
	output tfc_pkg::tfc_word_t faulting_address_o,
	output tfc_pkg::tfc_word_t page_table_pointer_o
);

	// ==========================================
	// Declarations
	tfc_word_t faulting_address;
	tfc_word_t next_faulting_address;
	tfc_word_t page_table_pointer;
	tfc_word_t next_page_table_pointer;
	tfc_word_t pointer_field_select;
	tfc_word_t next_pointer_field_select;
	tfc_word_t pointer_view;
	tfc_word_t pointer_out;
	tfc_word_t next_pointer_out;

	tfc_word_t byte_mask;
	tfc_word_t effective_select;
	tfc_word_t field;
	tfc_word_t low_zero;
	tfc_shift_t shift;
	tfc_word_t sw_mask;
	tfc_word_t select_merged;
	tfc_word_t rd_select;
	tfc_word_t rd_caps;

	logic extended_mode;
	logic wr_pointer;
	logic wr_select;
	logic addr_fault;
	logic tlb_fault;
	tfc_exc_code_t code;

	// ==========================================
	// Bus front end
	tfc_wb_port u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.rd_fault_i(faulting_address),
		.rd_pointer_i(pointer_view),
		.rd_select_i(rd_select),
		.rd_caps_i(rd_caps),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.wr_pointer_o(wr_pointer),
		.wr_select_o(wr_select)
	);

	// Byte lanes of a write
	generate
		for (genvar b = 0; b < 4; b++) begin : g_lane
			assign byte_mask[8*b +: 8] = {8{wb_sel_i[b]}};
		end
	endgenerate

	// ==========================================
	// Mode and exception classification
	assign extended_mode = extended_pointer_present_i | smartmips_pointer_select_i;

	// Legacy mode behaves as a fixed select of 22:4
	assign effective_select = extended_mode ? pointer_field_select : `TFC_LEGACY_SELECT;

	assign code = tfc_exc_code_t'(exception_cause_code_i);

	always_comb begin
		addr_fault = 1'b0;
		tlb_fault = 1'b0;
		if (exc_strobe_i) begin
			unique case (code)
				TFC_EXC_ADDR_LOAD, TFC_EXC_ADDR_STORE: addr_fault = 1'b1;
				TFC_EXC_MODIFIED, TFC_EXC_TLB_LOAD, TFC_EXC_TLB_STORE: tlb_fault = 1'b1;
				default: begin
					addr_fault = 1'b0;
					tlb_fault = 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// Field decode of the active select
	// Relies on software keeping the run of ones contiguous
	tfc_field_decode u_decode (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.select_i(effective_select),
		.field_o(field),
		.low_zero_o(low_zero),
		.shift_o(shift)
	);

	// ==========================================
	// Faulting address
	always_comb begin
		next_faulting_address = faulting_address;
		if (addr_fault | tlb_fault) begin
			next_faulting_address = exc_vaddr_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			faulting_address <= `TFC_FAULT_RESET;
		end else begin
			faulting_address <= next_faulting_address;
		end
	end

	// ==========================================
	// Page table pointer
	// Update order inside one cycle:
	// - a software write reaches only bits outside the field
	// - a translation fault then refills the field from the address
	// - bits below the field keep what software wrote but read zero
	// Storing the low bits avoids a second mask on the write path;
	// the read view and the refill output both apply the zero mask.
	// A write and a fault in one cycle therefore never fight:
	// they own disjoint bit sets of the register.
	// Field bits belong to hardware; software writes reach only the rest
	assign sw_mask = byte_mask & ~field;

	always_comb begin
		next_page_table_pointer = page_table_pointer;
		if (wr_pointer) begin
			next_page_table_pointer = (page_table_pointer & ~sw_mask)
				| (wb_dat_i & sw_mask);
		end
		// Address errors leave the page number as it was
		if (tlb_fault) begin
			// VA bit i+shift lands in pointer bit i, inside the field only
			next_page_table_pointer = (next_page_table_pointer & ~field)
				| (tfc_word_t'(exc_vaddr_i >> shift) & field);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_table_pointer <= `TFC_POINTER_RESET;
		end else begin
			page_table_pointer <= next_page_table_pointer;
		end
	end

	// Shift 0 with all ones copies the whole address; no ones shields everything
	assign pointer_view = page_table_pointer & ~low_zero;

	// ==========================================
	// Pointer field select
	assign select_merged = (pointer_field_select & ~byte_mask) | (wb_dat_i & byte_mask);

	always_comb begin
		next_pointer_field_select = pointer_field_select;
		// Writes ignored when the register is absent
		if (wr_select && extended_mode) begin
			// Pointer may be stale until rewritten; no repair is attempted
			next_pointer_field_select = (select_merged & `TFC_SELECT_IMPL)
				| (`TFC_SELECT_FIXED & ~`TFC_SELECT_IMPL);
		end
	end

	// Reset to the 4K single-level value; any contiguous run is accepted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pointer_field_select <= (`TFC_LEGACY_SELECT & `TFC_SELECT_IMPL)
				| (`TFC_SELECT_FIXED & ~`TFC_SELECT_IMPL);
		end else begin
			pointer_field_select <= next_pointer_field_select;
		end
	end

	assign rd_select = extended_mode ? pointer_field_select : 32'h0000_0000;

	// ==========================================
	// Capability word
	// Straps are static levels from core configuration, so no
	// synchroniser; changing them at run time leaves the pointer stale.
	// Either strap alone switches the block into extended mode.
	always_comb begin
		rd_caps = 32'h0000_0000;
		rd_caps[`TFC_CAP_EXT_BIT] = extended_pointer_present_i;
		rd_caps[`TFC_CAP_SM_BIT] = smartmips_pointer_select_i;
	end

	// ==========================================
	// Outputs
	always_comb begin
		next_pointer_out = next_page_table_pointer & ~low_zero;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pointer_out <= `TFC_POINTER_RESET;
		end else begin
			pointer_out <= next_pointer_out;
		end
	end

	assign faulting_address_o = faulting_address;
	assign page_table_pointer_o = pointer_out;

endmodule : tfc_fault_context

// ---- shared/tfc_map.svh ----
// Register offsets, field positions and reset values of the fault context block.
// Assumes inclusion by bare name from the package, which the design files import.
`ifndef TFC_MAP_SVH
`define TFC_MAP_SVH

// ==========================================
// Register byte offsets
`define TFC_OFS_FAULT 8'h00
`define TFC_OFS_POINTER 8'h04
`define TFC_OFS_SELECT 8'h08
`define TFC_OFS_CAPS 8'h0C

// ==========================================
// Capability word bit positions
`define TFC_CAP_EXT_BIT 0
`define TFC_CAP_SM_BIT 1

// ==========================================
// Field select layouts
// Legacy layout: page number in 22:4, zeros in 3:0
`define TFC_LEGACY_SELECT 32'h007F_FFF0
`define TFC_LEGACY_SHIFT 6'h09
`define TFC_LEGACY_LOW 32'h0000_000F
// Implemented select bits; unimplemented ones read the fixed value
`define TFC_SELECT_IMPL 32'hFFFF_FFFF
`define TFC_SELECT_FIXED 32'h0000_0000

// ==========================================
// Reset values
`define TFC_FAULT_RESET 32'h0000_0000
`define TFC_POINTER_RESET 32'h0000_0000

`endif

// ---- shared/tfc_pkg.sv ----
// Types shared by the fault context block.
// Assumes the map header sits beside it on the include path.
`include "tfc_map.svh"

package tfc_pkg;

	typedef logic [31:0] tfc_word_t;
	typedef logic [4:0] tfc_code_t;
	typedef logic [7:0] tfc_addr_t;
	typedef logic [5:0] tfc_shift_t;

	// Exception cause codes that this block reacts to
	typedef enum logic [4:0] {
		TFC_EXC_MODIFIED = 5'h01,
		TFC_EXC_TLB_LOAD = 5'h02,
		TFC_EXC_TLB_STORE = 5'h03,
		TFC_EXC_ADDR_LOAD = 5'h04,
		TFC_EXC_ADDR_STORE = 5'h05
	} tfc_exc_code_t;

endpackage : tfc_pkg

// ---- logic/tfc_wb_port.sv ----
// Classic Wishbone slave front end: acknowledge, write strobes, read mux.
// Assumes a single-cycle classic master that holds its request until ack.
`timescale 1ns/1ps

module tfc_wb_port
	import tfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire tfc_pkg::tfc_addr_t wb_adr_i,
	input wire tfc_pkg::tfc_word_t rd_fault_i,
	input wire tfc_pkg::tfc_word_t rd_pointer_i,
	input wire tfc_pkg::tfc_word_t rd_select_i,
	input wire tfc_pkg::tfc_word_t rd_caps_i,
	output logic wb_ack_o,
	output tfc_pkg::tfc_word_t wb_dat_o,
	output logic wr_pointer_o,
	output logic wr_select_o
);

	logic ack;
	logic next_ack;
	tfc_word_t dat;
	tfc_word_t next_dat;
	logic req;

	assign req = wb_cyc_i & wb_stb_i;

	// ==========================================
	// Acknowledge and read data
	always_comb begin
		next_ack = req & ~ack;
		next_dat = dat;
		if (req & ~ack) begin
			unique case (wb_adr_i)
				`TFC_OFS_FAULT: next_dat = rd_fault_i;
				`TFC_OFS_POINTER: next_dat = rd_pointer_i;
				`TFC_OFS_SELECT: next_dat = rd_select_i;
				`TFC_OFS_CAPS: next_dat = rd_caps_i;
				default: next_dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			dat <= 32'h0000_0000;
		end else begin
			ack <= next_ack;
			dat <= next_dat;
		end
	end

	// Writes land on the edge where the master sees ack
	assign wr_pointer_o = req & wb_we_i & ack & (wb_adr_i == `TFC_OFS_POINTER);
	assign wr_select_o = req & wb_we_i & ack & (wb_adr_i == `TFC_OFS_SELECT);
	assign wb_ack_o = ack;
	assign wb_dat_o = dat;

endmodule : tfc_wb_port

// ---- logic/tfc_field_decode.sv ----
// Decodes a field select mask into shift, field and read-as-zero masks.
// Assumes the mask holds one contiguous run of ones, or none.
`timescale 1ns/1ps

module tfc_field_decode
	import tfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tfc_pkg::tfc_word_t select_i,
	output tfc_pkg::tfc_word_t field_o,
	output tfc_pkg::tfc_word_t low_zero_o,
	output tfc_pkg::tfc_shift_t shift_o
);

	tfc_word_t below;
	tfc_word_t next_low;
	tfc_shift_t next_shift;
	tfc_word_t field;
	tfc_word_t low_zero;
	tfc_shift_t shift;

	// ==========================================
	// Bits below the lowest one read as zero
	generate
		for (genvar i = 0; i < 32; i++) begin : g_below
			if (i == 0) begin : g_first
				assign below[i] = ~select_i[i];
			end else begin : g_rest
				assign below[i] = below[i-1] & ~select_i[i];
			end
		end
	endgenerate

	// Shift is the count of zeros above the run, i.e. 32 - X
	always_comb begin
		logic seen;
		seen = 1'b0;
		next_shift = 6'h00;
		next_low = below & {32{|select_i}};
		for (int i = 31; i >= 0; i--) begin
			if (select_i[i]) begin
				seen = 1'b1;
			end else if (!seen) begin
				next_shift = next_shift + 6'h01;
			end
		end
	end

	// Registered: a select change is briefly stale, which is allowed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			field <= `TFC_LEGACY_SELECT;
			low_zero <= `TFC_LEGACY_LOW;
			shift <= `TFC_LEGACY_SHIFT;
		end else begin
			field <= select_i;
			low_zero <= next_low;
			shift <= next_shift;
		end
	end

	assign field_o = field;
	assign low_zero_o = low_zero;
	assign shift_o = shift;

endmodule : tfc_field_decode

// ---- verification/tfc_fault_context_props.sv ----
// Checker on the ports of the fault context block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module tfc_fault_context_props
	import tfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic exc_strobe_i,
	input wire tfc_pkg::tfc_code_t exception_cause_code_i,
	input wire tfc_pkg::tfc_word_t exc_vaddr_i,
	input wire logic extended_pointer_present_i,
	input wire logic smartmips_pointer_select_i,
	input wire tfc_pkg::tfc_word_t faulting_address_o,
	input wire tfc_pkg::tfc_word_t page_table_pointer_o
);
	// ==========================================
	// Helpers
	logic tlb;
	logic adr_err;
	logic legacy;
	assign tlb = exc_strobe_i && exception_cause_code_i inside {5'h1, 5'h2, 5'h3};
	assign adr_err = exc_strobe_i && exception_cause_code_i inside {5'h4, 5'h5};
	assign legacy = !extended_pointer_present_i && !smartmips_pointer_select_i;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ==========================================
	// Assertions
	chk_fault_load: assert property (
		tlb || adr_err |=> faulting_address_o == $past(exc_vaddr_i))
		else $error("faulting address not loaded");
	chk_fault_keep: assert property (
		!(tlb || adr_err) |=> $stable(faulting_address_o))
		else $error("faulting address changed without cause");
	chk_legacy_fill: assert property (
		legacy && tlb |=> page_table_pointer_o[22:4] == $past(exc_vaddr_i[31:13]))
		else $error("page number not filled");
	chk_low_zero: assert property (
		legacy |-> page_table_pointer_o[3:0] == 4'h0)
		else $error("low pointer bits not zero");
	// Guard on ack: a software write lands on the same edge
	chk_base_keep: assert property (
		legacy && tlb && !wb_ack_o |=> $stable(page_table_pointer_o[31:23]))
		else $error("table base touched by exception");
	chk_adr_err_ptr: assert property (
		adr_err && !wb_ack_o |=> $stable(page_table_pointer_o))
		else $error("pointer changed on address error");
	chk_ack_next: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	cov_ext_fill: cover property (tlb && !legacy);
	cov_leg_fill: cover property (tlb && legacy);
	cov_adr_err: cover property (adr_err);
endmodule : tfc_fault_context_props

bind tfc_fault_context tfc_fault_context_props chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .exc_strobe_i, .exception_cause_code_i, .exc_vaddr_i,
	.extended_pointer_present_i, .smartmips_pointer_select_i, .faulting_address_o,
	.page_table_pointer_o);

// ---- verification/tfc_core_model.sv ----
// Model of the core exception sequencing that feeds the block.
// Assumes the bench calls raise() and shares clk_i.
`timescale 1ns/1ps

module tfc_core_model
	import tfc_pkg::*;
(
	input wire logic clk_i,
	output tfc_pkg::tfc_code_t cause_o,
	output tfc_pkg::tfc_word_t vaddr_o,
	output logic strobe_o
);
	initial begin
		strobe_o = 1'b0;
		cause_o = 5'h0;
		vaddr_o = 32'h0000_0000;
	end

	// One-cycle entry pulse; address turns to junk after it
	task automatic raise(input tfc_code_t c, input tfc_word_t va);
		@(posedge clk_i);
		strobe_o <= 1'b1;
		cause_o <= c;
		vaddr_o <= va;
		@(posedge clk_i);
		strobe_o <= 1'b0;
		vaddr_o <= ~va;
	endtask : raise
endmodule : tfc_core_model

// ---- verification/tfc_fault_context_tb_top.sv ----
// Bench for the fault context block over classic Wishbone.
// Assumes the core model drives the exception inputs.
`timescale 1ns/1ps

module tfc_fault_context_tb_top;
	import tfc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic ext = 1'b0;
	logic sm = 1'b0;
	logic ack;
	logic strobe;
	tfc_code_t cause;
	tfc_addr_t adr = 8'h00;
	tfc_word_t dat = 32'h0000_0000;
	tfc_word_t dat_o, fa, ptr, vaddr;
	int mismatches = 0;
	int cmp_count = 0;
	tfc_word_t masks [6] = '{32'h007F_FFF0, 32'h003F_FFF8, 32'h007F_FFF8,
		32'h00FF_FFF8, 32'hFFFF_FFFF, 32'h0000_0000};

	always #2 clk_i = ~clk_i;

	tfc_fault_context uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .exc_strobe_i(strobe), .exception_cause_code_i(cause),
		.exc_vaddr_i(vaddr), .extended_pointer_present_i(ext),
		.smartmips_pointer_select_i(sm), .faulting_address_o(fa),
		.page_table_pointer_o(ptr));
	tfc_core_model core (.clk_i(clk_i), .cause_o(cause), .vaddr_o(vaddr), .strobe_o(strobe));

	// ==========================================
	// Tasks
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	task automatic wb(input tfc_addr_t a, input logic w, input tfc_word_t d,
		output tfc_word_t q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		adr <= a;
		we <= w;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			mismatches++;
		q = dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic rd_chk(input string what, input tfc_addr_t a, input tfc_word_t e);
		tfc_word_t q;
		wb(a, 1'b0, 32'h0000_0000, q);
		cmp_count++;
		if (q !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", what, e, q);
		end
	endtask : rd_chk

	task automatic wr(input tfc_addr_t a, input tfc_word_t d);
		tfc_word_t q;
		wb(a, 1'b1, d, q);
	endtask : wr

	task automatic reset;
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : reset

	// Field gets the top address bits; bits under the run read zero
	function automatic tfc_word_t exp_ptr(tfc_word_t m, tfc_word_t b, tfc_word_t va);
		int sh;
		tfc_word_t low;
		sh = 0;
		low = 32'h0000_0000;
		for (int i = 0; i < 32; i++)
			if (m[i]) sh = 31 - i;
		for (int i = 31; i >= 0; i--)
			if (m[i]) low = (32'h0000_0001 << i) - 1;
		return (b & ~m & ~low) | ((va >> sh) & m);
	endfunction : exp_ptr

	// ==========================================
	// Tests
	initial begin
		tfc_word_t va, fexp, pexp;
		reset();
		rd_chk("fault reset", 8'h00, 32'h0000_0000);
		rd_chk("select absent", 8'h08, 32'h0000_0000);
		rd_chk("caps", 8'h0C, 32'h0000_0000);
		rd_chk("unmapped", 8'h10, 32'h0000_0000);
		wr(8'h04, 32'hFFFF_FFFF);
		pexp = 32'hFF80_0000;
		rd_chk("pointer base", 8'h04, pexp);
		fexp = 32'h0000_0000;
		for (int c = 0; c < 7; c++) begin
			va = 32'h89AB_CDEF + c * 32'h0110_2203;
			core.raise(5'(c), va);
			if (c >= 1 && c <= 5)
				fexp = va;
			if (c >= 1 && c <= 3)
				pexp = exp_ptr(32'h007F_FFF0, pexp, va);
			rd_chk("fault", 8'h00, fexp);
			rd_chk("pointer", 8'h04, pexp);
			cmp_count++;
			if (fa !== fexp || ptr !== pexp) begin
				mismatches++;
				$display("unexpected outputs exp %h %h got %h %h", fexp, pexp, fa, ptr);
			end
		end
		wr(8'h00, 32'h0000_0000);
		rd_chk("fault write", 8'h00, fexp);
		$display("test legacy done");
		for (int cfg = 1; cfg < 3; cfg++) begin
			{sm, ext} <= 2'(cfg);
			reset();
			rd_chk("caps ext", 8'h0C, 32'(cfg));
			rd_chk("select reset", 8'h08, 32'h007F_FFF0);
			foreach (masks[k]) begin
				va = 32'hD1E2_F304 ^ (k << 20);
				wr(8'h08, masks[k]);
				rd_chk("select", 8'h08, masks[k]);
				wr(8'h04, 32'hA5C3_5A3C);
				core.raise(5'h3, va);
				pexp = exp_ptr(masks[k], 32'hA5C3_5A3C, va);
				rd_chk("ext pointer", 8'h04, pexp);
				cmp_count++;
				if (ptr !== pexp || fa !== va) begin
					mismatches++;
					$display("unexpected ext outputs exp %h %h got %h %h", pexp, va, ptr, fa);
				end
			end
			$display("test extended %0d done", cfg);
		end
		report_and_stop();
	end

	initial begin
		#(5000 * 4);
		$display("watchdog expired");
		mismatches++;
		report_and_stop();
	end
endmodule : tfc_fault_context_tb_top
